// *** dv/tb_usb_endpoint_ctrl_regs_8_to_11.sv ***
`timescale 1ns/1ps
// Self-checking bench for the endpoint 8 to 11 control bank
module tb_usb_endpoint_ctrl_regs_8_to_11;
    logic                 clk = 1'b0;       // 100 MHz
    logic                 arst_n = 1'b0;    // Active-low reset
    logic [15:0]          awaddr = '0;      // Write address
    logic [15:0]          araddr = '0;      // Read address
    logic [31:0]          wdata = '0;       // Write data
    logic [3:0]           wstrb = '0;       // Byte strobes
    logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                 awready, wready, bvalid, arready, rvalid;
    logic [1:0]           bresp, rresp;
    logic [31:0]          rdata;
    ep_ctrl_pkg::token_t  token;            // Driven by the host model
    ep_ctrl_pkg::answer_t answer;
    int                   fails = 0;
    int                   check_count = 0;

    // Free-running clock
    always #5 clk = ~clk;

    ep_ctrl_bank dut (.CLK_I(clk), .ARST_N_I(arst_n),
        .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
        .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .TOKEN_I(token), .ANSWER_O(answer));

    usb_host_model host (.clk_i(clk), .token_o(token), .answer_i(answer));

    // Report and stop
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    // Four-state compare
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // Byte address from a register's printed index
    function automatic logic [15:0] ea(input int i);
        return {ep_ctrl_pkg::EP_IDX_TABLE[i], 2'b00};
    endfunction : ea

    // Write: address and data together, each dropped when taken
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r, input logic [3:0] s = 4'hf);
        int n;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            fails++;
            conclude();
        end
    endtask : wr

    // Read: response sampled at the handshake edge
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
        if (n == 50) begin
            fails++;
            conclude();
        end
    endtask : rd

    // Reset values, field storage, unused bits, unmapped slot
    task automatic regs_scenario;
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++) begin
            rd(ea(i), d, r);
            check("reset value", 32'h0, d);
        end
        for (int i = 0; i < 4; i++) wr(ea(i), 32'hffffffe0 | (i * 9 + 1), r);
        for (int i = 0; i < 4; i++) begin
            rd(ea(i), d, r);
            check("stored fields", (i * 9 + 1), d);
            check("read response", 32'h0, {30'h0, r});
        end
        // Low byte lane off: answered but nothing stored
        wr(ea(1), 32'h1f, r, 4'he);
        check("masked write response", 32'h0, {30'h0, r});
        rd(ea(1), d, r);
        check("masked write kept", 32'ha, d);
        wr(ea(0) + 16'h0004, 32'h1f, r); // Gap between two registers
        check("unmapped write response", 32'h2, {30'h0, r});
        rd(ea(0) + 16'h0004, d, r);
        check("unmapped read", 32'h2, {d[29:0], r});
    endtask : regs_scenario

    // Mid-run reset clears every register written by the policy sweep
    task automatic reset_scenario;
        logic [31:0] d;
        logic [1:0]  r;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(ea(i), d, r);
            check("value after reset", 32'h0, d);
        end
    endtask : reset_scenario

    // Every field combination against every token kind
    task automatic policy_scenario;
        ep_ctrl_pkg::answer_t ans;
        logic [1:0]           r;
        logic                 acc;
        logic                 ok;
        logic [1:0]           hs;
        for (int v = 0; v < 32; v++) begin
            wr(ea(v % 4), v, r);
            for (int k = 0; k < 3; k++) begin
                host.send(4'(8 + v % 4), ep_ctrl_pkg::token_kind_t'(k), ans);
                ok = (k == 0) ? v[3] : (k == 1) ? v[2] : (v[3] & v[2] & ~v[4]);
                acc = ok & ~(v[1] & v[0]);
                hs = !v[0] ? 2'h0 : v[1] ? 2'h2 : ok ? 2'h1 : 2'h0;
                check("answer", {28'h0, 1'b1, acc, hs}, {28'h0, ans});
            end
        end
        host.send(4'h7, ep_ctrl_pkg::TOKEN_IN, ans);
        check("foreign endpoint answer", 32'h0, {31'h0, ans.valid});
    endtask : policy_scenario

    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        regs_scenario();
        policy_scenario();
        reset_scenario();
        conclude();
    end
endmodule : tb_usb_endpoint_ctrl_regs_8_to_11

// *** dv/usb_host_model.sv ***
`timescale 1ns/1ps
// Serial engine stand-in that offers tokens and collects answers
module usb_host_model (
    input  wire logic                 clk_i,
    output ep_ctrl_pkg::token_t       token_o,
    input  wire ep_ctrl_pkg::answer_t answer_i
);
    // Idle until a token is offered
    initial token_o = '0;

    // One-cycle token, answer read once it has settled
    task automatic send(input logic [3:0] ep, input ep_ctrl_pkg::token_kind_t kind,
                        output ep_ctrl_pkg::answer_t ans);
        @(posedge clk_i);
        token_o <= '{valid: 1'b1, ep: ep, kind: kind};
        @(posedge clk_i);
        token_o <= '{valid: 1'b0, ep: ~ep, kind: kind}; // Stale fields changed on purpose
        #1 ans = answer_i;
    endtask : send
endmodule : usb_host_model

// *** rtl/ep_ctrl_bank.sv ***
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Endpoints 8 to 11 sit two indices apart
// - Fields in bits 4..0, read/write, reset zero
// - Bidirectional with disable set: SETUP refused
// - Bidirectional with disable clear: SETUP accepted
// - Disable bit ignored unless both directions enabled
// - Receive enable gates incoming data
// - Transmit enable gates outgoing data
// - Stall bit reports the endpoint stalled; here only while handshake enable is set, otherwise the stall bit has no effect
// - Handshake enable makes handshakes sent
// - Handshake clear: no handshake packets at all
module ep_ctrl_bank (
    input  wire logic                               CLK_I,
    input  wire logic                               ARST_N_I,
    // AXI4-Lite write address
    input  wire logic [ep_ctrl_pkg::ADDR_W-1:0]     S_AXI_AWADDR_I,
    input  wire logic                               S_AXI_AWVALID_I,
    output logic                                    S_AXI_AWREADY_O,
    // AXI4-Lite write data
    input  wire logic [ep_ctrl_pkg::DATA_W-1:0]     S_AXI_WDATA_I,
    input  wire logic [3:0]                         S_AXI_WSTRB_I,
    input  wire logic                               S_AXI_WVALID_I,
    output logic                                    S_AXI_WREADY_O,
    // AXI4-Lite write response
    output logic [1:0]                              S_AXI_BRESP_O,
    output logic                                    S_AXI_BVALID_O,
    input  wire logic                               S_AXI_BREADY_I,
    // AXI4-Lite read address
    input  wire logic [ep_ctrl_pkg::ADDR_W-1:0]     S_AXI_ARADDR_I,
    input  wire logic                               S_AXI_ARVALID_I,
    output logic                                    S_AXI_ARREADY_O,
    // AXI4-Lite read data
    output logic [ep_ctrl_pkg::DATA_W-1:0]          S_AXI_RDATA_O,
    output logic [1:0]                              S_AXI_RRESP_O,
    output logic                                    S_AXI_RVALID_O,
    input  wire logic                               S_AXI_RREADY_I,
    // Serial engine token request and answer
    input  ep_ctrl_pkg::token_t                     TOKEN_I,
    output ep_ctrl_pkg::answer_t                    ANSWER_O
);

    localparam int NUM_EP = ep_ctrl_pkg::NUM_EP;
    localparam int IDX_W  = ep_ctrl_pkg::IDX_W;

    // Write channel state
    logic                         aw_ready_reg;            // Address slot free
    logic                         w_ready_reg;             // Data slot free
    logic                         aw_full_reg;             // Address held
    logic                         w_full_reg;              // Data held
    logic [IDX_W-1:0]             aw_idx_reg;              // Held word index
    logic [7:0]                   w_byte_reg;              // Held low data byte
    logic                         w_lane_reg;              // Low byte lane enabled
    logic                         bvalid_reg;              // Response pending
    logic [1:0]                   bresp_reg;               // Response code
    // Read channel state
    logic                         ar_ready_reg;            // Read slot free
    logic                         rvalid_reg;              // Read data pending
    logic [1:0]                   rresp_reg;               // Read response code
    logic [ep_ctrl_pkg::DATA_W-1:0] rdata_reg;             // Read data word
    // Token answer
    ep_ctrl_pkg::answer_t         answer_reg;              // Registered answer

    // Decode and register array
    logic                         wr_do;                   // Write performed this cycle
    logic [NUM_EP-1:0]            wr_sel;                  // One-hot write target
    logic                         wr_hit;                  // Write address mapped
    logic [NUM_EP-1:0]            rd_sel;                  // One-hot read target
    logic                         rd_hit;                  // Read address mapped
    logic [IDX_W-1:0]             rd_idx;                  // Read word index
    ep_ctrl_pkg::ep_ctrl_t        ep_q [NUM_EP];           // Register contents
    ep_ctrl_pkg::ep_ctrl_t        rd_ctrl;                 // Selected read value
    ep_ctrl_pkg::ep_ctrl_t        tok_ctrl;                // Fields of the token's endpoint
    logic                         tok_hit;                 // Token addresses this bank
    logic [3:0]                   tok_off;                 // Endpoint offset within bank
    logic                         pol_accept;              // Policy verdict
    ep_ctrl_pkg::handshake_t      pol_hs;                  // Policy handshake

    assign rd_idx = S_AXI_ARADDR_I[ep_ctrl_pkg::ADDR_W-1:2];
    // Write fires once both halves are held and the previous response is gone
    assign wr_do  = aw_full_reg && w_full_reg && !bvalid_reg;

    // Per-endpoint decode and storage
    genvar k;
    generate
        for (k = 0; k < NUM_EP; k++) begin : g_ep
            // Each register owns one printed index
            assign wr_sel[k] = (aw_idx_reg == ep_ctrl_pkg::EP_IDX_TABLE[k]);
            assign rd_sel[k] = (rd_idx == ep_ctrl_pkg::EP_IDX_TABLE[k]);
            ep_ctrl_reg u_reg (
                .clk_i    (CLK_I),
                .arst_n_i (ARST_N_I),
                .write_i  (wr_do && wr_sel[k] && w_lane_reg),
                .data_i   (w_byte_reg),
                .ctrl_o   (ep_q[k])
            );
        end
    endgenerate

    assign wr_hit = |wr_sel;
    assign rd_hit = |rd_sel;

    // Read mux; unmapped reads give zero
    always_comb begin
        rd_ctrl = ep_ctrl_pkg::EP_CTRL_RESET;
        for (int i = 0; i < NUM_EP; i++) begin
            if (rd_sel[i]) begin
                rd_ctrl = ep_q[i];
            end
        end
    end

    // Write address slot
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            aw_ready_reg <= 1'b0;
            aw_full_reg  <= 1'b0;
            aw_idx_reg   <= '0;
        end else if (S_AXI_AWVALID_I && aw_ready_reg) begin
            aw_ready_reg <= 1'b0;                          // Hold until response taken
            aw_full_reg  <= 1'b1;
            aw_idx_reg   <= S_AXI_AWADDR_I[ep_ctrl_pkg::ADDR_W-1:2];
        end else if (bvalid_reg && S_AXI_BREADY_I) begin
            aw_ready_reg <= 1'b1;
            aw_full_reg  <= 1'b0;
        end else if (!aw_full_reg) begin
            aw_ready_reg <= 1'b1;                          // Opens on first edge after reset
        end
    end

    // Write data slot; only the low lane carries register bits
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            w_ready_reg <= 1'b0;
            w_full_reg  <= 1'b0;
            w_byte_reg  <= 8'h00;
            w_lane_reg  <= 1'b0;
        end else if (S_AXI_WVALID_I && w_ready_reg) begin
            w_ready_reg <= 1'b0;
            w_full_reg  <= 1'b1;
            w_byte_reg  <= S_AXI_WDATA_I[7:0];
            w_lane_reg  <= S_AXI_WSTRB_I[0];               // Upper lanes hold nothing
        end else if (bvalid_reg && S_AXI_BREADY_I) begin
            w_ready_reg <= 1'b1;
            w_full_reg  <= 1'b0;
        end else if (!w_full_reg) begin
            w_ready_reg <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= ep_ctrl_pkg::RESP_OKAY;
        end else if (wr_do) begin
            bvalid_reg <= 1'b1;
            // Unmapped addresses store nothing and say so
            bresp_reg  <= wr_hit ? ep_ctrl_pkg::RESP_OKAY : ep_ctrl_pkg::RESP_SLVERR;
        end else if (bvalid_reg && S_AXI_BREADY_I) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read channel; data captured at address acceptance
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            ar_ready_reg <= 1'b0;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= ep_ctrl_pkg::RESP_OKAY;
            rdata_reg    <= '0;
        end else if (S_AXI_ARVALID_I && ar_ready_reg) begin
            ar_ready_reg <= 1'b0;
            rvalid_reg   <= 1'b1;
            rresp_reg    <= rd_hit ? ep_ctrl_pkg::RESP_OKAY : ep_ctrl_pkg::RESP_SLVERR;
            // Unimplemented upper bits always zero
            rdata_reg    <= {27'h0000000, rd_ctrl};
        end else if (rvalid_reg && S_AXI_RREADY_I) begin
            rvalid_reg   <= 1'b0;
            ar_ready_reg <= 1'b1;
        end else if (!rvalid_reg) begin
            ar_ready_reg <= 1'b1;
        end
    end

    // Token lookup; other endpoint numbers belong to other banks
    always_comb begin
        tok_off  = TOKEN_I.ep - ep_ctrl_pkg::FIRST_EP_NUM;
        tok_hit  = (TOKEN_I.ep >= ep_ctrl_pkg::FIRST_EP_NUM) && (tok_off < 4'(NUM_EP));
        tok_ctrl = ep_ctrl_pkg::EP_CTRL_RESET;
        for (int i = 0; i < NUM_EP; i++) begin
            if (tok_off == 4'(i)) begin
                tok_ctrl = ep_q[i];
            end
        end
    end

    ep_policy u_policy (
        .ctrl_i   (tok_ctrl),
        .kind_i   (TOKEN_I.kind),
        .accept_o (pol_accept),
        .hs_o     (pol_hs)
    );

    // Answer registered one cycle after the token
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            answer_reg <= '{valid: 1'b0, accept: 1'b0, hs: ep_ctrl_pkg::HS_NONE};
        end else if (TOKEN_I.valid && tok_hit) begin
            answer_reg <= '{valid: 1'b1, accept: pol_accept, hs: pol_hs};
        end else begin
            answer_reg <= '{valid: 1'b0, accept: 1'b0, hs: ep_ctrl_pkg::HS_NONE};
        end
    end

    // Port drive, all from flops
    assign S_AXI_AWREADY_O = aw_ready_reg;
    assign S_AXI_WREADY_O  = w_ready_reg;
    assign S_AXI_BVALID_O  = bvalid_reg;
    assign S_AXI_BRESP_O   = bresp_reg;
    assign S_AXI_ARREADY_O = ar_ready_reg;
    assign S_AXI_RVALID_O  = rvalid_reg;
    assign S_AXI_RRESP_O   = rresp_reg;
    assign S_AXI_RDATA_O   = rdata_reg;
    assign ANSWER_O        = answer_reg;

    // Sequences shared by the token checks
    sequence s_tok(ep_ctrl_pkg::token_kind_t kd);
        TOKEN_I.valid && tok_hit && TOKEN_I.kind == kd;
    endsequence

    sequence s_bidir_ep;
        tok_ctrl.receive_enable && tok_ctrl.transmit_enable && !tok_ctrl.stall_status;
    endsequence

    property p_ep9_map;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        wr_do && w_lane_reg && aw_idx_reg == ep_ctrl_pkg::ENDPOINT9_CONTROL_IDX |=> ep_q[1] == $past(w_byte_reg[4:0]);
    endproperty
    a_ep9_map: assert property (p_ep9_map) else $error("Endpoint 9 index not mapped");

    property p_write_answer;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        wr_do |=> S_AXI_BVALID_O ##0 (S_AXI_BVALID_O throughout (!S_AXI_AWREADY_O [*1]));
    endproperty
    a_write_answer: assert property (p_write_answer) else $error("Write response missing");

    property p_upper_zero;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        $rose(S_AXI_RVALID_O) |-> S_AXI_RDATA_O[31:5] == 27'h0000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("Upper read bits not zero");

    property p_setup_refused;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        s_tok(ep_ctrl_pkg::TOKEN_SETUP) ##0 s_bidir_ep ##0 tok_ctrl.control_transfer_disable
        |=> ANSWER_O.valid && !ANSWER_O.accept;
    endproperty
    a_setup_refused: assert property (p_setup_refused) else $error("SETUP accepted while disabled");

    property p_setup_taken;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        s_tok(ep_ctrl_pkg::TOKEN_SETUP) ##0 s_bidir_ep ##0 !tok_ctrl.control_transfer_disable
        |=> ANSWER_O.valid && ANSWER_O.accept;
    endproperty
    a_setup_taken: assert property (p_setup_taken) else $error("SETUP refused on control endpoint");

    property p_disable_ignored;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        s_tok(ep_ctrl_pkg::TOKEN_OUT) ##0 !tok_ctrl.transmit_enable ##0 !tok_ctrl.stall_status
        |=> ANSWER_O.accept == $past(tok_ctrl.receive_enable);
    endproperty
    a_disable_ignored: assert property (p_disable_ignored) else $error("Disable bit affected OUT");

    property p_rx_gate;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        s_tok(ep_ctrl_pkg::TOKEN_OUT) ##0 !tok_ctrl.stall_status
        |=> ANSWER_O.valid && ANSWER_O.accept == $past(tok_ctrl.receive_enable);
    endproperty
    a_rx_gate: assert property (p_rx_gate) else $error("Receive gate wrong");

    property p_tx_gate;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        s_tok(ep_ctrl_pkg::TOKEN_IN) ##0 !tok_ctrl.stall_status
        |=> ANSWER_O.valid && ANSWER_O.accept == $past(tok_ctrl.transmit_enable);
    endproperty
    a_tx_gate: assert property (p_tx_gate) else $error("Transmit gate wrong");

    property p_stall_answer;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        TOKEN_I.valid && tok_hit && tok_ctrl.stall_status && tok_ctrl.handshake_enable
        |=> ANSWER_O.hs == ep_ctrl_pkg::HS_STALL && !ANSWER_O.accept;
    endproperty
    a_stall_answer: assert property (p_stall_answer) else $error("Stall not answered");

    property p_ack_answer;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        TOKEN_I.valid && tok_hit && tok_ctrl.handshake_enable && !tok_ctrl.stall_status
        |=> ANSWER_O.accept == (ANSWER_O.hs == ep_ctrl_pkg::HS_ACK);
    endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("ACK does not match acceptance");

    property p_no_handshake;
        @(posedge CLK_I) disable iff (!ARST_N_I)
        TOKEN_I.valid && tok_hit && !tok_ctrl.handshake_enable |=> ANSWER_O.hs == ep_ctrl_pkg::HS_NONE;
    endproperty
    a_no_handshake: assert property (p_no_handshake) else $error("Handshake sent while disabled");

endmodule : ep_ctrl_bank

// *** rtl/ep_ctrl_pkg.sv ***
package ep_ctrl_pkg;

    // Bus geometry
    localparam int ADDR_W = 16;                            // Byte address width on the register bus
    localparam int IDX_W  = ADDR_W - 2;                    // Word index width
    localparam int DATA_W = 32;                            // Register bus data width
    localparam int NUM_EP = 4;                             // Endpoints held by this bank
    localparam int FIELD_W = 5;                            // Implemented bits per control register

    // Register indices as printed; byte address is four times the index
    localparam logic [IDX_W-1:0] ENDPOINT8_CONTROL_IDX  = 14'h063a;
    localparam logic [IDX_W-1:0] ENDPOINT9_CONTROL_IDX  = 14'h063c;
    localparam logic [IDX_W-1:0] ENDPOINT10_CONTROL_IDX = 14'h063e;
    localparam logic [IDX_W-1:0] ENDPOINT11_CONTROL_IDX = 14'h0640;
    localparam logic [IDX_W-1:0] EP_IDX_TABLE [NUM_EP] = '{ENDPOINT8_CONTROL_IDX, ENDPOINT9_CONTROL_IDX,
                                                           ENDPOINT10_CONTROL_IDX, ENDPOINT11_CONTROL_IDX};
    localparam logic [3:0]       FIRST_EP_NUM = 4'h8;      // USB endpoint number of the first register

    // Field positions inside a control register
    localparam int CONTROL_TRANSFER_DISABLE_BIT = 4;
    localparam int RECEIVE_ENABLE_BIT           = 3;
    localparam int TRANSMIT_ENABLE_BIT          = 2;
    localparam int STALL_STATUS_BIT             = 1;
    localparam int HANDSHAKE_ENABLE_BIT         = 0;

    // Reset value of every control register
    localparam logic [FIELD_W-1:0] EP_CTRL_RESET = 5'h00;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One endpoint's control fields, bit 4 first
    typedef struct packed {
        logic control_transfer_disable;                    // Bit 4
        logic receive_enable;                              // Bit 3
        logic transmit_enable;                             // Bit 2
        logic stall_status;                                // Bit 1
        logic handshake_enable;                            // Bit 0
    } ep_ctrl_t;

    // Token kinds offered by the serial engine
    typedef enum logic [1:0] {TOKEN_OUT, TOKEN_IN, TOKEN_SETUP} token_kind_t;

    // Handshake the serial engine should emit
    typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_STALL} handshake_t;

    // Token request from the serial engine
    typedef struct packed {
        logic        valid;                                // One-cycle request strobe
        logic [3:0]  ep;                                   // USB endpoint number
        token_kind_t kind;                                 // Token type
    } token_t;

    // Answer back to the serial engine
    typedef struct packed {
        logic       valid;                                 // One-cycle answer strobe
        logic       accept;                                // Transaction data accepted or produced
        handshake_t hs;                                    // Handshake to send
    } answer_t;

endpackage : ep_ctrl_pkg

// *** rtl/ep_ctrl_reg.sv ***
`timescale 1ns/1ps
// One endpoint control register; upper bits are not stored at all
module ep_ctrl_reg (
    input  wire logic                 clk_i,
    input  wire logic                 arst_n_i,
    input  wire logic                 write_i,
    input  wire logic [7:0]           data_i,
    output ep_ctrl_pkg::ep_ctrl_t     ctrl_o
);

    ep_ctrl_pkg::ep_ctrl_t ctrl_reg;                       // Stored fields

    // Write takes the low five bits only
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_reg <= ep_ctrl_pkg::EP_CTRL_RESET;
        end else if (write_i) begin
            ctrl_reg <= ep_ctrl_pkg::ep_ctrl_t'(data_i[ep_ctrl_pkg::FIELD_W-1:0]);
        end
    end

    assign ctrl_o = ctrl_reg;

    property p_write_stores;
        @(posedge clk_i) disable iff (!arst_n_i)
        write_i |=> ctrl_reg == $past(data_i[4:0]);
    endproperty
    a_write_stores: assert property (p_write_stores) else $error("Write not stored");

    property p_hold_without_write;
        @(posedge clk_i) disable iff (!arst_n_i)
        !write_i |=> $stable(ctrl_reg);
    endproperty
    a_hold_without_write: assert property (p_hold_without_write) else $error("Register changed");

endmodule : ep_ctrl_reg

// *** rtl/ep_policy.sv ***
`timescale 1ns/1ps
// Decides acceptance and handshake for one token against one endpoint's fields
module ep_policy (
    input  ep_ctrl_pkg::ep_ctrl_t      ctrl_i,
    input  ep_ctrl_pkg::token_kind_t   kind_i,
    output logic                       accept_o,
    output ep_ctrl_pkg::handshake_t    hs_o
);

    logic bidir;                                           // Both directions enabled
    logic stalled;                                         // Stall answered by handshake
    logic dir_ok;                                          // Direction gate passes

    always_comb begin
        bidir   = ctrl_i.receive_enable && ctrl_i.transmit_enable;
        stalled = ctrl_i.stall_status && ctrl_i.handshake_enable;
        case (kind_i)
            // Incoming data needs reception enabled
            ep_ctrl_pkg::TOKEN_OUT:   dir_ok = ctrl_i.receive_enable;
            // Outgoing data needs transmission enabled
            ep_ctrl_pkg::TOKEN_IN:    dir_ok = ctrl_i.transmit_enable;
            // Control only on a bidirectional endpoint; disable bit matters only there
            ep_ctrl_pkg::TOKEN_SETUP: dir_ok = bidir && !ctrl_i.control_transfer_disable;
            default:                  dir_ok = 1'b0;
        endcase
        // A stalled endpoint moves no data only while handshake enable is set
        accept_o = dir_ok && !stalled;
        if (!ctrl_i.handshake_enable) begin
            hs_o = ep_ctrl_pkg::HS_NONE;
        end else if (ctrl_i.stall_status) begin
            hs_o = ep_ctrl_pkg::HS_STALL;
        end else if (dir_ok) begin
            hs_o = ep_ctrl_pkg::HS_ACK;
        end else begin
            hs_o = ep_ctrl_pkg::HS_NONE;                   // Disabled direction stays silent
        end
    end

endmodule : ep_policy
